// ### core/sent_frame_transmitter.sv
// Single-edge nibble frame transmitter with an input sample FIFO and APB registers.
// Assumes angle samples and alarm inputs are synchronous to pclk.
`timescale 1ns/1ps

module sent_fifo #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] count_ff;
   logic [AW:0] nxt_count;
   logic in_ready_ff;
   logic push;
   logic pop;

   assign push = in_valid & in_ready_ff;
   assign pop = out_ready & (count_ff != '0);
   assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
   assign in_ready = in_ready_ff;
   assign out_valid = count_ff != '0;
   assign out_data = mem_ff[rd_ff];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
         count_ff <= '0;
         in_ready_ff <= 1'b0;
      end else begin
         wr_ff <= push ? AW'((wr_ff + 1'b1) % DEPTH) : wr_ff;
         rd_ff <= pop ? AW'((rd_ff + 1'b1) % DEPTH) : rd_ff;
         count_ff <= nxt_count;
         in_ready_ff <= nxt_count != (AW+1)'(DEPTH);
      end
   end

   // Storage has no reset; only written slots are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end
endmodule

module sent_frame_transmitter #(
   parameter int unsigned ANGLE_W = 12,
   parameter int unsigned FIFO_DEPTH = 32
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Angle samples
   input wire logic angle_valid,
   input wire logic [ANGLE_W-1:0] angle_data,
   output logic angle_ready,
   // Diagnostic sources
   input wire logic mag_high_alarm,
   input wire logic mag_low_alarm,
   input wire logic txfreq_alarm,
   input wire logic agc_alarm,
   input wire logic nvm_double_err,
   input wire logic shadow_parity_err,
   input wire logic rx_coil_fault,
   input wire logic proc_overflow,
   // Output pin, shared with pin_programming_link
   output logic sent_o,
   output logic sent_oe,
   input wire logic sent_i
);
   sent_pkg::tx_state_t st_ff;
   sent_pkg::tx_state_t nxt_st;
   logic [sent_pkg::CTRL_W-1:0] ctrl_ff;
   logic [11:0] zero_ff;
   logic [7:0] tick_div_ff;
   logic [7:0] div_cnt_ff;
   logic tick;
   logic [8:0] sym_tick_ff;
   logic [8:0] nxt_sym_tick;
   logic [8:0] frame_ticks_ff;
   logic [2:0] nib_idx_ff;
   logic [3:0] nib_ff [sent_pkg::NIB_COUNT];
   logic [3:0] nxt_nib [sent_pkg::NIB_COUNT];
   logic [7:0] roll_ff;
   logic [11:0] pos_ff;
   logic [11:0] angle_now;
   logic [11:0] pos_now;
   logic [3:0] cur_nib;
   logic [8:0] sym_len;
   logic end_sym;
   logic run;
   logic start_frame;
   logic diag;
   logic [sent_pkg::ALARM_W-1:0] alarms;
   logic fifo_valid;
   logic [ANGLE_W-1:0] fifo_data;
   logic sent_o_ff;
   logic sent_oe_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic setup;
   logic wr_en;
   logic mapped;
   logic [31:0] rd_mux;

   // Multiply the remainder by x^4 modulo the generator
   function automatic logic [3:0] crc_shift4(input logic [3:0] c);
      logic [3:0] r;
      r = c;
      for (int i = 0; i < 4; i++) begin
         r = {r[2:0], 1'b0} ^ (r[3] ? sent_pkg::CRC_POLY : 4'h0);
      end
      return r;
   endfunction

   // Revision three appends one zero nibble to the data before closing
   function automatic logic [3:0] frame_crc(input logic [23:0] d, input logic rev3);
      logic [3:0] c;
      c = sent_pkg::CRC_SEED;
      for (int i = 5; i >= 0; i--) begin
         c = crc_shift4(c) ^ d[i*4 +: 4];
      end
      if (rev3) begin
         c = crc_shift4(c);
      end
      return c;
   endfunction

   sent_fifo #(.WIDTH(ANGLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(angle_valid),
      .in_data(angle_data),
      .in_ready(angle_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(start_frame)
   );

   assign alarms = {mag_high_alarm, mag_low_alarm, txfreq_alarm, agc_alarm,
                    nvm_double_err, shadow_parity_err, rx_coil_fault, proc_overflow};
   assign diag = |alarms;
   assign run = ctrl_ff[sent_pkg::CTRL_ENABLE] & ~ctrl_ff[sent_pkg::CTRL_PROG];
   // At-or-past compare: a shorter period written mid-count cannot stretch one tick to 256 cycles
   assign tick = div_cnt_ff >= tick_div_ff - 8'h01;
   // Oldest queued sample, else repeat the last one so frames never stall
   assign angle_now = fifo_valid ? 12'(fifo_data) : pos_ff;
   assign pos_now = ctrl_ff[sent_pkg::CTRL_FALLING] ? zero_ff - angle_now : angle_now - zero_ff;

   assign nxt_nib[0] = diag ? sent_pkg::STATUS_DIAG : sent_pkg::STATUS_NORMAL;
   assign nxt_nib[1] = pos_now[11:8];
   assign nxt_nib[2] = pos_now[7:4];
   assign nxt_nib[3] = pos_now[3:0];
   assign nxt_nib[4] = ctrl_ff[sent_pkg::CTRL_FORMAT2] ? 4'h0 : roll_ff[7:4];
   assign nxt_nib[5] = ctrl_ff[sent_pkg::CTRL_FORMAT2] ? 4'h0 : roll_ff[3:0];
   assign nxt_nib[6] = ctrl_ff[sent_pkg::CTRL_FORMAT2] ? 4'h0 : ~pos_now[11:8];
   assign nxt_nib[7] = frame_crc({nxt_nib[1], nxt_nib[2], nxt_nib[3], nxt_nib[4], nxt_nib[5], nxt_nib[6]},
                                 ctrl_ff[sent_pkg::CTRL_CRC_REV3]);

   // Symbol timing
   assign cur_nib = nib_ff[nib_idx_ff];
   assign sym_len = (st_ff == sent_pkg::ST_SYNC) ? sent_pkg::SYNC_TICKS
                  : sent_pkg::NIB_BASE_TICKS + 9'(cur_nib);
   assign end_sym = tick & ((st_ff == sent_pkg::ST_PAUSE) ? frame_ticks_ff == sent_pkg::FRAME_TICKS - 9'h001
                                                          : sym_tick_ff == sym_len - 9'h001);

   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         sent_pkg::ST_IDLE: if (run && tick) nxt_st = sent_pkg::ST_SYNC;
         sent_pkg::ST_SYNC: if (end_sym) nxt_st = sent_pkg::ST_NIB;
         sent_pkg::ST_NIB: begin
            if (end_sym && nib_idx_ff == sent_pkg::LAST_NIB) begin
               if (ctrl_ff[sent_pkg::CTRL_PAUSE]) begin
                  nxt_st = sent_pkg::ST_PAUSE;
               end else begin
                  nxt_st = run ? sent_pkg::ST_SYNC : sent_pkg::ST_IDLE;
               end
            end
         end
         sent_pkg::ST_PAUSE: if (end_sym) nxt_st = run ? sent_pkg::ST_SYNC : sent_pkg::ST_IDLE;
      endcase
   end

   assign start_frame = (nxt_st == sent_pkg::ST_SYNC) && (st_ff != sent_pkg::ST_SYNC);
   assign nxt_sym_tick = (end_sym || start_frame) ? 9'h000 : sym_tick_ff + 9'(tick);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_ff <= 8'h00;
      end else begin
         div_cnt_ff <= tick ? 8'h00 : div_cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= sent_pkg::ST_IDLE;
         sym_tick_ff <= 9'h000;
         frame_ticks_ff <= 9'h000;
         nib_idx_ff <= 3'h0;
      end else begin
         st_ff <= nxt_st;
         sym_tick_ff <= nxt_sym_tick;
         frame_ticks_ff <= start_frame ? 9'h000 : frame_ticks_ff + 9'(tick);
         nib_idx_ff <= (st_ff == sent_pkg::ST_NIB && end_sym) ? nib_idx_ff + 3'h1 : nib_idx_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         roll_ff <= 8'h00;
         pos_ff <= 12'h000;
         for (int i = 0; i < sent_pkg::NIB_COUNT; i++) begin
            nib_ff[i] <= 4'h0;
         end
      end else if (start_frame) begin
         roll_ff <= roll_ff + 8'h01;
         pos_ff <= angle_now;
         for (int i = 0; i < sent_pkg::NIB_COUNT; i++) begin
            nib_ff[i] <= nxt_nib[i];
         end
      end
   end

   // Pin released while the programming link owns the wire
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sent_o_ff <= 1'b1;
         sent_oe_ff <= 1'b0;
      end else begin
         sent_o_ff <= (nxt_st == sent_pkg::ST_IDLE) || (nxt_sym_tick >= sent_pkg::LOW_TICKS);
         sent_oe_ff <= ~ctrl_ff[sent_pkg::CTRL_PROG];
      end
   end
   assign sent_o = sent_o_ff;
   assign sent_oe = sent_oe_ff;

   // APB slave, zero wait states
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready_ff & pwrite & ~pslverr_ff;
   assign mapped = paddr == sent_pkg::REG_CTRL || paddr == sent_pkg::REG_ZERO || paddr == sent_pkg::REG_TICK
                || paddr == sent_pkg::REG_STATUS || paddr == sent_pkg::REG_ALARM;
   assign rd_mux = (paddr == sent_pkg::REG_CTRL) ? 32'(ctrl_ff)
                 : (paddr == sent_pkg::REG_ZERO) ? 32'(zero_ff)
                 : (paddr == sent_pkg::REG_TICK) ? 32'(tick_div_ff)
                 : (paddr == sent_pkg::REG_STATUS) ? {19'h00000, sent_i, diag, roll_ff, st_ff, fifo_valid}
                 : (paddr == sent_pkg::REG_ALARM) ? 32'(alarms) : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= setup;
         pslverr_ff <= setup & ~mapped;
         prdata_ff <= setup ? rd_mux : prdata_ff;
      end
   end
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata = prdata_ff;

   // Out-of-window tick periods are clamped so the timebase stays legal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= sent_pkg::CTRL_RESET;
         zero_ff <= sent_pkg::ZERO_RESET;
         tick_div_ff <= sent_pkg::TICK_TYP_CYC;
      end else if (wr_en) begin
         if (paddr == sent_pkg::REG_CTRL) ctrl_ff <= pwdata[sent_pkg::CTRL_W-1:0];
         if (paddr == sent_pkg::REG_ZERO) zero_ff <= pwdata[11:0];
         if (paddr == sent_pkg::REG_TICK) begin
            tick_div_ff <= (pwdata[7:0] < sent_pkg::TICK_MIN_CYC || pwdata[31:8] != 24'h000000)
                           ? ((pwdata[31:8] != 24'h000000) ? sent_pkg::TICK_MAX_CYC : sent_pkg::TICK_MIN_CYC)
                           : (pwdata[7:0] > sent_pkg::TICK_MAX_CYC) ? sent_pkg::TICK_MAX_CYC : pwdata[7:0];
         end
      end
   end

   sequence s_nib_end;
      st_ff == sent_pkg::ST_NIB && end_sym;
   endsequence
   sequence s_sync_end;
      st_ff == sent_pkg::ST_SYNC && end_sym;
   endsequence
   a_nibble_low_phase: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff == sent_pkg::ST_NIB && sym_tick_ff < sent_pkg::LOW_TICKS |-> !sent_o_ff)
      else $error("nibble low phase not low");
   a_nibble_length: assert property (@(posedge pclk) disable iff (!presetn)
      s_nib_end |-> sym_tick_ff == sent_pkg::NIB_BASE_TICKS + 9'(cur_nib) - 9'h001)
      else $error("nibble length wrong");
   a_tick_window: assert property (@(posedge pclk) disable iff (!presetn)
      tick_div_ff >= sent_pkg::TICK_MIN_CYC && tick_div_ff <= sent_pkg::TICK_MAX_CYC)
      else $error("tick period outside window");
   a_sync_shape: assert property (@(posedge pclk) disable iff (!presetn)
      s_sync_end |-> sym_tick_ff == sent_pkg::SYNC_TICKS - 9'h001 && sent_o_ff ##1 st_ff == sent_pkg::ST_NIB)
      else $error("sync pulse shape wrong");
   a_sync_then_status: assert property (@(posedge pclk) disable iff (!presetn)
      s_sync_end |=> nib_idx_ff == 3'h0 && !sent_o_ff)
      else $error("status nibble does not follow sync");
   a_frame_fixed_len: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff == sent_pkg::ST_PAUSE && end_sym |-> frame_ticks_ff == sent_pkg::FRAME_TICKS - 9'h001)
      else $error("paused frame not 270 ticks");
   a_status_top_zero: assert property (@(posedge pclk) disable iff (!presetn)
      nib_ff[0][3:2] == 2'b00)
      else $error("status bits 2 or 3 set");
   a_diag_code: assert property (@(posedge pclk) disable iff (!presetn)
      start_frame |=> nib_ff[0] == ($past(diag) ? sent_pkg::STATUS_DIAG : sent_pkg::STATUS_NORMAL))
      else $error("status code does not follow diagnostic state");
   a_inverse_msn: assert property (@(posedge pclk) disable iff (!presetn)
      start_frame && !ctrl_ff[sent_pkg::CTRL_FORMAT2] |=> nib_ff[6] == ~nib_ff[1])
      else $error("inverted nibble mismatch");
   a_unpaused_len: assert property (@(posedge pclk) disable iff (!presetn)
      (s_nib_end and (nib_idx_ff == sent_pkg::LAST_NIB && !ctrl_ff[sent_pkg::CTRL_FORMAT2]))
      |-> frame_ticks_ff >= 9'h097 && frame_ticks_ff <= 9'h103)
      else $error("format one frame length out of range");
   a_roll_step: assert property (@(posedge pclk) disable iff (!presetn)
      start_frame |=> roll_ff == $past(roll_ff) + 8'h01)
      else $error("rolling counter did not step");
   a_prog_release: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_ff[sent_pkg::CTRL_PROG] |=> !sent_oe_ff)
      else $error("pin driven during programming");
endmodule

// ### core/sent_pkg.sv
// Constants for the single-edge nibble frame transmitter.
// Assumes a 50 MHz pclk and APB register access.
package sent_pkg;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned TICK_MIN_NS = 3000;
   localparam int unsigned TICK_TYP_NS = 3360;
   localparam int unsigned TICK_MAX_NS = 3670;
   // Least time rounds up, longest time rounds down
   localparam logic [7:0] TICK_MIN_CYC = 8'((TICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] TICK_TYP_CYC = 8'(TICK_TYP_NS / CLK_PERIOD_NS);
   localparam logic [7:0] TICK_MAX_CYC = 8'(TICK_MAX_NS / CLK_PERIOD_NS);

   localparam logic [8:0] LOW_TICKS = 9'h005;
   localparam logic [8:0] NIB_BASE_TICKS = 9'h00C;
   localparam logic [8:0] SYNC_TICKS = 9'h038;
   localparam logic [8:0] FRAME_TICKS = 9'h10E;
   localparam logic [2:0] LAST_NIB = 3'h7;
   localparam int unsigned NIB_COUNT = 8;

   localparam logic [3:0] STATUS_NORMAL = 4'h0;
   localparam logic [3:0] STATUS_DIAG = 4'h3;
   localparam logic [3:0] CRC_SEED = 4'h5;
   localparam logic [3:0] CRC_POLY = 4'hD;

   // Register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ZERO = 8'h04;
   localparam logic [7:0] REG_TICK = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_ALARM = 8'h10;

   // Control fields
   localparam int unsigned CTRL_ENABLE = 0;
   localparam int unsigned CTRL_FORMAT2 = 1;
   localparam int unsigned CTRL_PAUSE = 2;
   localparam int unsigned CTRL_CRC_REV3 = 3;
   localparam int unsigned CTRL_FALLING = 4;
   localparam int unsigned CTRL_PROG = 5;
   localparam int unsigned CTRL_W = 6;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [11:0] ZERO_RESET = 12'h000;
   localparam int unsigned ALARM_W = 8;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SYNC = 2'b01,
      ST_NIB = 2'b10,
      ST_PAUSE = 2'b11
   } tx_state_t;
endpackage

// ### test/sent_rx_model.sv
// Receiving end of the single-edge nibble line: measures pulses in ticks.
// Assumes the tick length in pclk cycles and the pause setting are known up front.
`timescale 1ns/1ps

module sent_rx_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Line and expected setup
   input wire logic line,
   input wire logic [7:0] tick_cyc,
   input wire logic pause_en,
   // Decoded frame
   output logic [31:0] nibs,
   output logic [3:0] slot,
   output logic [9:0] frame_ticks,
   output logic frame_done,
   output logic low_err
);
   logic line_d;
   int cyc;
   int low_cyc;
   int acc;
   wire fall = line_d && !line;
   wire frame_end = (slot == 4'h9 && !pause_en) || slot == 4'hA;

   // Slot 1 is the sync pulse, 2..9 the nibbles, A the pause
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_d <= 1'b1;
         cyc <= 0;
         low_cyc <= 0;
         acc <= 0;
         slot <= 4'h0;
         nibs <= 32'h0;
         frame_ticks <= 10'h000;
         frame_done <= 1'b0;
         low_err <= 1'b0;
      end else begin
         line_d <= line;
         frame_done <= 1'b0;
         cyc <= fall ? 1 : cyc + 1;
         low_cyc <= line ? 0 : low_cyc + 1;
         if (line && !line_d && low_cyc != 5 * tick_cyc)
            low_err <= 1'b1;
         if (fall) begin
            if (slot != 4'h0 && cyc % tick_cyc != 0)
               low_err <= 1'b1;
            if (slot == 4'h1 && cyc != 56 * tick_cyc)
               low_err <= 1'b1;
            if (slot >= 4'h2 && slot <= 4'h9)
               nibs[4 * (9 - slot) +: 4] <= 4'(cyc / tick_cyc - 12);
            acc <= (slot == 4'h1) ? cyc : acc + cyc;
            if (frame_end) begin
               frame_ticks <= 10'((acc + cyc) / tick_cyc);
               frame_done <= 1'b1;
            end
            case (slot)
               4'h0: slot <= 4'h1;
               4'h9: slot <= pause_en ? 4'hA : 4'h1;
               4'hA: slot <= 4'h1;
               default: slot <= slot + 4'h1;
            endcase
         end
      end
   end
endmodule

// ### test/tb_sent_frame_transmitter.sv
// Testbench for the nibble frame transmitter: registers, sample fill, two frames.
// Assumes sent_rx_model on the line and a 50 MHz pclk.
`timescale 1ns/1ps

module tb_sent_frame_transmitter;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, rdy;
   logic [7:0] paddr, alarms, cnt_a;
   logic [31:0] pwdata, prdata, rd, nibs;
   logic angle_valid, angle_ready, sent_o, sent_oe, prog_drv, pause_en, frame_done, low_err;
   logic [11:0] angle_data;
   logic [3:0] slot;
   logic [9:0] frame_ticks;
   int miscompares, cmp_count, n;
   wire pin = sent_oe ? sent_o : prog_drv;
   wire rx_line = sent_oe ? sent_o : 1'b1;

   sent_frame_transmitter u_sent_frame_transmitter (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .angle_valid(angle_valid), .angle_data(angle_data), .angle_ready(angle_ready),
      .mag_high_alarm(alarms[7]), .mag_low_alarm(alarms[6]), .txfreq_alarm(alarms[5]),
      .agc_alarm(alarms[4]), .nvm_double_err(alarms[3]), .shadow_parity_err(alarms[2]),
      .rx_coil_fault(alarms[1]), .proc_overflow(alarms[0]), .sent_o(sent_o), .sent_oe(sent_oe),
      .sent_i(pin));

   sent_rx_model u_sent_rx_model (
      .clk(pclk), .rst_n(presetn), .line(rx_line), .tick_cyc(8'h96), .pause_en(pause_en),
      .nibs(nibs), .slot(slot), .frame_ticks(frame_ticks), .frame_done(frame_done), .low_err(low_err));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic test_done;
      $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One idle edge before each setup so psel never changes twice in a step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         $display("Error at %0t: no pready on the register bus", $time);
         miscompares++;
         test_done();
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask

   task automatic wait_ev(input logic done_ev, input int lim);
      logic hit;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         hit = done_ev ? frame_done : (slot == 4'hA);
      end while (hit !== 1'b1 && n < lim);
      if (hit !== 1'b1) begin
         $display("Error at %0t: line event timed out", $time);
         miscompares++;
         test_done();
      end
   endtask

   // Seed 5, x^4+x^3+x^2+1; the newer scheme adds one zero nibble
   function automatic logic [3:0] crc4(input logic [23:0] d, input logic rev3);
      logic [3:0] c;
      c = 4'h5;
      for (int k = 0; k < 6 + rev3; k++) begin
         for (int b = 0; b < 4; b++)
            c = {c[2:0], 1'b0} ^ (c[3] ? 4'hD : 4'h0);
         c = c ^ ((k < 6) ? d[23 - 4 * k -: 4] : 4'h0);
      end
      return c;
   endfunction

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      angle_valid = 1'b0;
      angle_data = 12'h9AB;
      alarms = 8'h00;
      prog_drv = 1'b1;
      pause_en = 1'b1;
      miscompares = 0;
      cmp_count = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(sent_pkg::REG_CTRL, 32'h0, "ctrl reset");
      rdchk(sent_pkg::REG_ZERO, 32'h0, "zero reset");
      rdchk(sent_pkg::REG_TICK, 32'hA8, "tick reset");
      apb(1'b1, sent_pkg::REG_TICK, 32'hFF);
      rdchk(sent_pkg::REG_TICK, 32'hB7, "tick upper clamp");
      apb(1'b1, sent_pkg::REG_TICK, 32'h01);
      rdchk(sent_pkg::REG_TICK, 32'h96, "tick lower clamp");
      apb(1'b0, 8'h14, 32'h0);
      chk({rd[30:0], err}, 32'h1, "unmapped access");
      for (int i = 0; i < 8; i++) begin
         alarms <= 8'h01 << i;
         rdchk(sent_pkg::REG_ALARM, 32'h01 << i, "alarm input");
      end
      alarms <= 8'h00;
      prog_drv <= 1'b0;
      apb(1'b1, sent_pkg::REG_CTRL, 32'h20);
      rdchk(sent_pkg::REG_CTRL, 32'h20, "programming mode");
      apb(1'b0, sent_pkg::REG_STATUS, 32'h0);
      chk({30'h0, sent_oe, rd[12]}, 32'h0, "pin released");
      prog_drv <= 1'b1;
      apb(1'b1, sent_pkg::REG_CTRL, 32'h0);
      apb(1'b1, sent_pkg::REG_ZERO, 32'h123);
      n = 0;
      angle_valid <= 1'b1;
      do begin
         @(negedge pclk);
         rdy = angle_ready;
         @(posedge pclk);
         if (rdy)
            n++;
         angle_data <= (n == 1) ? 12'h456 : 12'(n);
      end while (rdy && n < 40);
      angle_valid <= 1'b0;
      chk(32'(n), 32'h20, "fifo fill");
      // Frame one: format two, pause, newer checksum, rising slope
      apb(1'b1, sent_pkg::REG_CTRL, 32'h0F);
      wait_ev(1'b0, 40000);
      apb(1'b1, sent_pkg::REG_CTRL, 32'h11);
      alarms <= 8'h80;
      pause_en <= 1'b0;
      wait_ev(1'b1, 25000);
      chk(nibs, {4'h0, 24'h888000, crc4(24'h888000, 1'b1)}, "frame one");
      chk({22'h0, frame_ticks}, 32'h10E, "frame one length");
      apb(1'b0, sent_pkg::REG_STATUS, 32'h0);
      cnt_a = rd[10:3];
      // Frame two: format one, no pause, older checksum, falling slope
      wait_ev(1'b1, 45000);
      apb(1'b0, sent_pkg::REG_STATUS, 32'h0);
      chk({rd[11], 23'h0, rd[10:3]}, {1'b1, 23'h0, cnt_a + 8'h01}, "diag and counter");
      chk({nibs[31:16], nibs[7:4]}, 20'h3CCD3, "frame two");
      chk({31'h0, nibs[15:8] == cnt_a || nibs[15:8] == cnt_a - 8'h01}, 32'h1, "counter sent");
      chk({28'h0, nibs[3:0]}, {28'h0, crc4(nibs[27:4], 1'b0)}, "frame two crc");
      n = 56;
      for (int k = 0; k < 8; k++)
         n += 12 + nibs[4 * k +: 4];
      chk({22'h0, frame_ticks}, 32'(n), "frame two length");
      chk({31'h0, low_err}, 32'h0, "pulse shapes");
      test_done();
   end
endmodule
